/* File: design/drive_protection_supervisor.sv */
// Protection supervisor: trips, speed loss and brake duty.
// Set up over APB.
// Assumes phase and contact pins are asynchronous;
// analog and brake inputs come from pclk logic.
// Notes on behaviour
// - With supervision on, any open output phase blocks the output.
// - Open-phase supervision enable is 0 off, 1 on, default off.
// - Input function code 18 is N.O. external trip, 19 is N.C.
// - Function codes span 0 to 27; input 4 defaults 3, input 5 defaults 4.
// - N.O. trip: open contact is normal, closed contact blocks output.
// - N.C. trip: closed contact is normal, opening it blocks output.
// - N.C. trip clears only with contact closed and function unchanged.
// - Output select 6 shows inverter overload trip; range 0-19, default 17.
// - Overcurrent trips after a delay shrinking as the excess grows.
// - Loss criterion: 0 off, 1 below half threshold, 2 below threshold.
// - Combined source, criterion 2: either input below its own threshold; voltage is compared with the combined threshold instead.
// - Loss acted on after qualification time, 0.1-120.0 s, default 1.0 s.
// - Loss reaction: 0 keep running, 1 coast block, 2 decelerate; default 0.
// - Output select 11 shows a speed-command loss.
// - Brake limit mode 0 unrestricted, 1 duty limited; default 1.
// - Brake duty 0-30 percent, default 10, applied only in mode 1.
// - Continuous braking stops after 15 seconds.
// - Duty limit bounds brake on-time per operation cycle; a fixed 10 s window is used instead.
`timescale 1ns/100ps
`default_nettype none
module drive_protection_supervisor
    import protect_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] phase_open,
    input wire logic digital_input_4,
    input wire logic digital_input_5,
    input wire logic [11:0] analog_voltage_input,
    input wire logic [11:0] analog_current_input,
    input wire logic [11:0] drive_input_current,
    input wire logic brake_request,
    output logic output_block,
    output logic decel_stop_req,
    output logic speed_loss_flag,
    output logic relay_output,
    output logic digital_output2,
    output logic brake_drive
);

    state_s s_q;
    state_s s_d;

    // Address decode shared by write enable and error answer
    function automatic logic addr_ok(input logic [7:0] a);
        logic ok;
        if (a == A_CTRL) ok = 1'b1;
        else if (a == A_FUNC) ok = 1'b1;
        else if (a == A_OSEL) ok = 1'b1;
        else if (a == A_QUAL) ok = 1'b1;
        else if (a == A_TH_V) ok = 1'b1;
        else if (a == A_TH_C) ok = 1'b1;
        else if (a == A_TH_I) ok = 1'b1;
        else if (a == A_DUTY) ok = 1'b1;
        else if (a == A_RATED) ok = 1'b1;
        else if (a == A_CLEAR) ok = 1'b1;
        else if (a == A_STATUS) ok = 1'b1;
        else ok = 1'b0;
        return ok;
    endfunction : addr_ok

    // Out-of-range codes keep the previous setting
    function automatic logic [4:0] keep5(input logic [4:0] v,
        input logic [4:0] old, input logic [4:0] max);
        return (v > max) ? old : v;
    endfunction : keep5

    // Output select decode, shared by both outputs
    function automatic logic out_sel(input logic [4:0] code,
        input status_s st);
        logic o;
        o = 1'b0;
        if (code == SEL_OVERLOAD) o = st.overload_trip;
        else if (code == SEL_SPEED_LOSS) o = st.speed_loss;
        return o;
    endfunction : out_sel

    logic access;
    logic xfer;
    logic wr;
    logic clr;
    logic [2:0] ph;
    logic in4;
    logic in5;
    logic ea_cause;
    logic eb_cause;
    logic eb_ok;
    logic over;
    logic [11:0] excess;
    logic [11:0] lim_v;
    logic [11:0] lim_c;
    logic [11:0] lim_i;
    logic loss_cond;
    logic loss_q;
    logic duty_ok;
    logic [31:0] rd;

    // APB answer: one wait state so read data leaves a flip-flop
    assign access = psel & penable;
    assign pready = access & s_q.ack;
    assign pslverr = pready & ~addr_ok(paddr);
    assign xfer = pready & addr_ok(paddr);
    assign wr = xfer & pwrite;
    assign clr = wr & (paddr == A_CLEAR) & pwdata[CLEAR_BIT];
    assign prdata = s_q.prdata;

    // Synchronised pins; contact high means closed to common
    assign ph = s_q.sync2[4:2];
    assign in4 = s_q.sync2[1];
    assign in5 = s_q.sync2[0];

    // Trip cause terms
    always_comb
    begin
        // closed contact on an 18-coded input
        ea_cause = ((s_q.func.lo == FN_EXT_A) & in4)
                 | ((s_q.func.hi == FN_EXT_A) & in5);
        // open contact on a 19-coded input
        eb_cause = ((s_q.func.lo == FN_EXT_B) & ~in4)
                 | ((s_q.func.hi == FN_EXT_B) & ~in5);
        // tripping input closed again, still coded 19
        eb_ok = s_q.etb_src ? ((s_q.func.hi == FN_EXT_B) & in5)
                            : ((s_q.func.lo == FN_EXT_B) & in4);
        over = drive_input_current > s_q.rated;
        excess = over ? (drive_input_current - s_q.rated) : 12'h000;
    end

    // Speed-command loss condition
    always_comb
    begin
        if (s_q.ctrl.speed_loss_criterion == CRIT_HALF)
        begin
            lim_v = s_q.th_v >> 1;
            lim_c = s_q.th_c >> 1;
            lim_i = s_q.th_i >> 1;
        end
        else
        begin
            lim_v = s_q.th_v;
            lim_c = s_q.th_c;
            lim_i = s_q.th_i;
        end
        if (s_q.ctrl.speed_loss_criterion == CRIT_OFF)
            loss_cond = 1'b0;
        else if (s_q.ctrl.speed_source == SRC_V)
            loss_cond = analog_voltage_input < lim_v;
        else if (s_q.ctrl.speed_source == SRC_I)
            loss_cond = analog_current_input < lim_i;
        else
            // voltage below the combined threshold, or current below its own
            loss_cond = (analog_voltage_input < lim_c)
                      | (analog_current_input < lim_i);
        loss_q = loss_cond & (s_q.loss_cnt >= s_q.qual);
    end

    // Read multiplexer
    always_comb
    begin
        rd = 32'h0000_0000;
        if (paddr == A_CTRL) rd = s_q.ctrl;
        else if (paddr == A_FUNC) rd = s_q.func;
        else if (paddr == A_OSEL) rd = s_q.osel;
        else if (paddr == A_QUAL) rd = {21'h0, s_q.qual};
        else if (paddr == A_TH_V) rd = {20'h0, s_q.th_v};
        else if (paddr == A_TH_C) rd = {20'h0, s_q.th_c};
        else if (paddr == A_TH_I) rd = {20'h0, s_q.th_i};
        else if (paddr == A_DUTY) rd = {27'h0, s_q.duty};
        else if (paddr == A_RATED) rd = {20'h0, s_q.rated};
        else if (paddr == A_STATUS) rd = s_q.st;
    end

    // Next-state logic for the whole block
    always_comb
    begin
        s_d = s_q;
        s_d.ack = access & ~s_q.ack;
        if (access & ~s_q.ack)
            s_d.prdata = rd;
        s_d.sync1 = {phase_open, digital_input_4, digital_input_5};
        s_d.sync2 = s_q.sync1;

        // Time base of 100 ms ticks
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1))
        begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end
        else
            s_d.tick_cnt = s_q.tick_cnt + 1'b1;

        // Register writes, on the completing edge only
        if (wr)
        begin
            if (paddr == A_CTRL)
                s_d.ctrl = ctrl_s'({24'h0, pwdata[7:0]});
            else if (paddr == A_FUNC)
            begin
                s_d.func.lo = keep5(pwdata[4:0], s_q.func.lo, FN_MAX);
                s_d.func.hi = keep5(pwdata[20:16], s_q.func.hi, FN_MAX);
            end
            else if (paddr == A_OSEL)
            begin
                s_d.osel.lo = keep5(pwdata[4:0], s_q.osel.lo, SEL_MAX);
                s_d.osel.hi = keep5(pwdata[20:16], s_q.osel.hi, SEL_MAX);
            end
            else if (paddr == A_QUAL)
            begin
                if (pwdata[10:0] < QUAL_MIN) s_d.qual = QUAL_MIN;
                else if (pwdata[31:11] != '0 || pwdata[10:0] > QUAL_MAX)
                    s_d.qual = QUAL_MAX;
                else s_d.qual = pwdata[10:0];
            end
            else if (paddr == A_TH_V) s_d.th_v = pwdata[11:0];
            else if (paddr == A_TH_C) s_d.th_c = pwdata[11:0];
            else if (paddr == A_TH_I) s_d.th_i = pwdata[11:0];
            else if (paddr == A_DUTY)
                s_d.duty = keep5(pwdata[4:0], s_q.duty, DUTY_MAX);
            else if (paddr == A_RATED) s_d.rated = pwdata[11:0];
        end

        // open phase; set wins over clear
        s_d.st.open_phase_trip = (s_q.ctrl.open_phase_enable & (|ph))
            | (s_q.st.open_phase_trip & ~clr);
        s_d.st.ext_a_trip = ea_cause | (s_q.st.ext_a_trip & ~clr);
        if (eb_cause)
        begin
            s_d.st.ext_b_trip = 1'b1;
            if (~s_q.st.ext_b_trip)
                s_d.etb_src = (s_q.func.lo != FN_EXT_B) | in4;
        end
        else if (clr & eb_ok)
            s_d.st.ext_b_trip = 1'b0;

        // inverse time: excess integrated per tick
        if (s_q.tick)
        begin
            if (over)
                s_d.ol_acc = (s_q.ol_acc > ~{8'h00, excess})
                    ? 20'hF_FFFF : s_q.ol_acc + {8'h00, excess};
            else if (s_q.ol_acc != '0)
                s_d.ol_acc = s_q.ol_acc - 1'b1;
        end
        if (clr & ~over)
        begin
            s_d.ol_acc = '0;
            s_d.st.overload_trip = 1'b0;
        end
        else if (s_q.ol_acc >= OL_TRIP_LEVEL)
            s_d.st.overload_trip = 1'b1;

        if (~loss_cond)
            s_d.loss_cnt = '0;
        else if (s_q.tick & (s_q.loss_cnt != QUAL_MAX))
            s_d.loss_cnt = s_q.loss_cnt + 1'b1;
        s_d.st.speed_loss = loss_q;
        s_d.st.decel_stop = loss_q
            & (s_q.ctrl.speed_loss_reaction == REACT_DECEL);
        s_d.st.speed_trip = (loss_q
            & (s_q.ctrl.speed_loss_reaction == REACT_COAST))
            | (s_q.st.speed_trip & ~(clr & ~loss_cond));

        if (s_q.tick)
        begin
            if (s_q.win_cnt == DUTY_WINDOW_TICKS - 1'b1)
            begin
                s_d.win_cnt = '0;
                s_d.on_cnt = '0;
            end
            else
            begin
                s_d.win_cnt = s_q.win_cnt + 1'b1;
                if (s_q.brake)
                    s_d.on_cnt = s_q.on_cnt + 1'b1;
            end
        end
        duty_ok = ~s_q.ctrl.brake_limit_mode
            | (s_q.on_cnt < {2'b00, s_q.duty});

        case (s_q.brk)
            BRK_IDLE:
            begin
                s_d.brk_run = '0;
                if (brake_request & duty_ok)
                    s_d.brk = BRK_ON;
            end
            BRK_ON:
            begin
                if (~brake_request | ~duty_ok)
                    s_d.brk = BRK_IDLE;
                else if (s_q.brk_run >= BRAKE_CAP_TICKS - 1'b1)
                begin
                    if (s_q.tick)
                        s_d.brk = BRK_CAPPED;
                end
                else if (s_q.tick)
                    s_d.brk_run = s_q.brk_run + 1'b1;
            end
            BRK_CAPPED:
            begin
                if (~brake_request)
                    s_d.brk = BRK_IDLE;
            end
            default: s_d.brk = BRK_IDLE;
        endcase
        s_d.st.brake_capped = (s_d.brk == BRK_CAPPED);
        s_d.brake = (s_d.brk == BRK_ON);

        // any latched trip blocks the output
        s_d.block = s_d.st.open_phase_trip | s_d.st.ext_a_trip
            | s_d.st.ext_b_trip | s_d.st.overload_trip
            | s_d.st.speed_trip;
        s_d.relay = out_sel(s_q.osel.lo, s_q.st);
        s_d.dout2 = out_sel(s_q.osel.hi, s_q.st);
    end

    // Single state register; reset loads defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.ctrl <= ctrl_s'(CTRL_RST);
            s_q.func <= pair5_s'(FUNC_RST);
            s_q.osel <= pair5_s'(OSEL_RST);
            s_q.qual <= QUAL_RST;
            s_q.th_v <= TH_V_RST;
            s_q.th_c <= TH_C_RST;
            s_q.th_i <= TH_I_RST;
            s_q.duty <= DUTY_RST;
            s_q.rated <= RATED_RST;
            s_q.brk <= BRK_IDLE;
        end
        else
            s_q <= s_d;
    end

    // Status outputs straight from flip-flops
    assign output_block = s_q.block;
    assign decel_stop_req = s_q.st.decel_stop;
    assign speed_loss_flag = s_q.st.speed_loss;
    assign relay_output = s_q.relay;
    assign digital_output2 = s_q.dout2;
    assign brake_drive = s_q.brake;

endmodule : drive_protection_supervisor
`default_nettype wire

/* File: design/protect_pkg.sv */
// Constants, register layouts and state types of the supervisor.
// Assumes a 25 MHz APB clock; timing derives from it.
package protect_pkg;
    // Clock and timing base
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_W = 22;
    localparam int unsigned BRAKE_CAP_S = 15;
    localparam logic [7:0] BRAKE_CAP_TICKS = 8'(BRAKE_CAP_S * 1000 / TICK_MS);
    localparam logic [6:0] DUTY_WINDOW_TICKS = 7'h64;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FUNC = 8'h04;
    localparam logic [7:0] A_OSEL = 8'h08;
    localparam logic [7:0] A_QUAL = 8'h0C;
    localparam logic [7:0] A_TH_V = 8'h10;
    localparam logic [7:0] A_TH_C = 8'h14;
    localparam logic [7:0] A_TH_I = 8'h18;
    localparam logic [7:0] A_DUTY = 8'h1C;
    localparam logic [7:0] A_RATED = 8'h20;
    localparam logic [7:0] A_CLEAR = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam int unsigned CLEAR_BIT = 0;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [31:0] FUNC_RST = 32'h0004_0003;
    localparam logic [31:0] OSEL_RST = 32'h0011_0011;
    localparam logic [10:0] QUAL_RST = 11'h00A;
    localparam logic [4:0] DUTY_RST = 5'h0A;
    localparam logic [11:0] TH_V_RST = 12'h200;
    localparam logic [11:0] TH_C_RST = 12'h200;
    localparam logic [11:0] TH_I_RST = 12'h200;
    localparam logic [11:0] RATED_RST = 12'h800;
    localparam logic [19:0] OL_TRIP_LEVEL = 20'h0_4000;
    // Codes and ranges
    localparam logic [4:0] FN_EXT_A = 5'h12;
    localparam logic [4:0] FN_EXT_B = 5'h13;
    localparam logic [4:0] FN_MAX = 5'h1B;
    localparam logic [4:0] SEL_OVERLOAD = 5'h06;
    localparam logic [4:0] SEL_SPEED_LOSS = 5'h0B;
    localparam logic [4:0] SEL_MAX = 5'h13;
    localparam logic [10:0] QUAL_MIN = 11'h001;
    localparam logic [10:0] QUAL_MAX = 11'h4B0;
    localparam logic [4:0] DUTY_MAX = 5'h1E;
    localparam logic [1:0] CRIT_OFF = 2'h0;
    localparam logic [1:0] CRIT_HALF = 2'h1;
    localparam logic [1:0] REACT_COAST = 2'h1;
    localparam logic [1:0] REACT_DECEL = 2'h2;
    localparam logic [1:0] SRC_V = 2'h0;
    localparam logic [1:0] SRC_I = 2'h1;

    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_ON = 2'b01,
        BRK_CAPPED = 2'b10
    } brake_e;

    typedef struct packed {
        logic [23:0] rsvd;
        logic [1:0] speed_source;
        logic [1:0] speed_loss_reaction;
        logic [1:0] speed_loss_criterion;
        logic brake_limit_mode;
        logic open_phase_enable;
    } ctrl_s;

    typedef struct packed {
        logic [10:0] rsvd_hi;
        logic [4:0] hi;
        logic [10:0] rsvd_lo;
        logic [4:0] lo;
    } pair5_s;

    typedef struct packed {
        logic [23:0] rsvd;
        logic brake_capped;
        logic decel_stop;
        logic speed_loss;
        logic speed_trip;
        logic overload_trip;
        logic ext_b_trip;
        logic ext_a_trip;
        logic open_phase_trip;
    } status_s;

    typedef struct packed {
        ctrl_s ctrl;
        pair5_s func;
        pair5_s osel;
        logic [10:0] qual;
        logic [11:0] th_v;
        logic [11:0] th_c;
        logic [11:0] th_i;
        logic [4:0] duty;
        logic [11:0] rated;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic ack;
        logic [31:0] prdata;
        status_s st;
        logic etb_src;
        logic [19:0] ol_acc;
        logic [10:0] loss_cnt;
        brake_e brk;
        logic [7:0] brk_run;
        logic [6:0] win_cnt;
        logic [6:0] on_cnt;
        logic brake;
        logic block;
        logic relay;
        logic dout2;
    } state_s;
endpackage : protect_pkg

/* File: sim/protect_checker.sv */
// Checker: APB timing and output relations.
// Assumes a bind to the top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module protect_checker
    import protect_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brake_request,
    input wire logic output_block,
    input wire logic decel_stop_req,
    input wire logic speed_loss_flag,
    input wire logic brake_drive
);
    localparam int unsigned CAP_LIM =
        (BRAKE_CAP_S * 1000 / TICK_MS + 1) * TICK_CYCLES + 4;
    int unsigned run_q;
    logic ld;
    logic clr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read data loads in the first access cycle
    assign ld = psel && penable && !pready;
    assign clr = psel && penable && pready && pwrite && paddr == A_CLEAR;
    // Unbroken braking run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 0;
        else
            run_q <= brake_drive ? run_q + 1 : 0;
    end
    AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("late ready");
    AST_SLVERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_READY_IDLE: assert property (!(psel && penable) |-> !pready)
        else $error("stray ready");
    AST_PRDATA_HOLD: assert property (!$past(ld) |-> $stable(prdata))
        else $error("read data moved");
    AST_BRAKE_CAUSE: assert property (brake_drive |-> $past(brake_request))
        else $error("brake unrequested");
    AST_BRAKE_CAP: assert property (run_q <= CAP_LIM)
        else $error("brake past cap");
    AST_DECEL_LOSS: assert property (decel_stop_req |-> speed_loss_flag)
        else $error("decel without loss");
    AST_BLOCK_HOLD: assert property ($fell(output_block) |-> $past(clr) || $past(clr, 2))
        else $error("block dropped unasked");
endmodule : protect_checker
bind drive_protection_supervisor protect_checker #(.TICK_CYCLES(TICK_CYCLES))
    protect_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .brake_request, .output_block,
    .decel_stop_req, .speed_loss_flag, .brake_drive);
`default_nettype wire

/* File: sim/plant_model.sv */
// Plant model: phases, contacts and analog sources.
// Assumes the bench sets states on the clock edge.
`timescale 1ns/100ps
`default_nettype none
module plant_model
(
    input wire logic [2:0] open_cmd,
    input wire logic close4_cmd,
    input wire logic close5_cmd,
    input wire logic [11:0] volt_cmd,
    input wire logic [11:0] curr_cmd,
    input wire logic [11:0] load_cmd,
    output logic [2:0] phase_open,
    output logic digital_input_4,
    output logic digital_input_5,
    output logic [11:0] analog_voltage_input,
    output logic [11:0] analog_current_input,
    output logic [11:0] drive_input_current
);
    assign phase_open = open_cmd;
    assign digital_input_4 = close4_cmd;
    assign digital_input_5 = close5_cmd;
    // Converter samples, one per clock
    assign analog_voltage_input = volt_cmd;
    assign analog_current_input = curr_cmd;
    assign drive_input_current = load_cmd;
endmodule : plant_model
`default_nettype wire

/* File: sim/drive_protection_supervisor_tb_top.sv */
// Bench: APB master, register model, protection scenarios.
// Assumes the plant model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module drive_protection_supervisor_tb_top;
    import protect_pkg::*;
    localparam int T = 10;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, brake_request = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, output_block, decel_stop_req, speed_loss_flag, e;
    logic relay_output, digital_output2, brake_drive, c4 = 0, c5 = 0;
    logic [2:0] phase_open, open_cmd = 0;
    logic digital_input_4, digital_input_5;
    logic [11:0] av, ai, dc, v_cmd = 12'hFFF, i_cmd = 12'hFFF, l_cmd = 0;
    int bad_count = 0, n_checks = 0, cyc = 0, t1, t2;
    int unsigned mreg [9] = '{32'h2, 32'h40003, 32'h110011, 32'hA, TH_V_RST,
        TH_C_RST, TH_I_RST, 32'hA, RATED_RST};

    drive_protection_supervisor #(.TICK_CYCLES(T))
        drive_protection_supervisor_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_open,
        .digital_input_4, .digital_input_5, .analog_voltage_input(av),
        .analog_current_input(ai), .drive_input_current(dc), .brake_request,
        .output_block, .decel_stop_req, .speed_loss_flag, .relay_output,
        .digital_output2, .brake_drive);
    plant_model plant_model_inst (.open_cmd, .close4_cmd(c4),
        .close5_cmd(c5), .volt_cmd(v_cmd), .curr_cmd(i_cmd), .load_cmd(l_cmd),
        .phase_open, .digital_input_4, .digital_input_5,
        .analog_voltage_input(av), .analog_current_input(ai),
        .drive_input_current(dc));

    // Clock and hang guard
    always #20 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    // One transfer; the slave sets the pace
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Model: bad codes keep the old field
    function automatic int unsigned fix(int a, int unsigned d, int unsigned o);
        int unsigned lim, lo, hi, q;
        lim = (a == 8) ? 19 : 27;
        lo = d & 31;
        hi = (d >> 16) & 31;
        q = d & 32'h7FF;
        case (a)
            0: return d & 32'hFF;
            4, 8: return ((hi > lim ? (o >> 16) & 31 : hi) << 16)
                | (lo > lim ? o & 31 : lo);
            12: return q < 1 ? 1 : (q > 1200 ? 1200 : q);
            28: return lo > 30 ? o : lo;
            default: return d & 32'hFFF;
        endcase
    endfunction : fix

    task automatic wr(input int a, input int unsigned d);
        apb(1, 8'(a), d);
        if (a < 36)
            mreg[a / 4] = fix(a, d, mreg[a / 4]);
    endtask : wr

    task automatic rd(input int a);
        apb(0, 8'(a), 0);
        chk(r, mreg[a / 4]);
    endtask : rd

    // Status poll, bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int k = 0;
        do
        begin
            apb(0, A_STATUS, 0);
            k++;
        end
        while ((r & m) !== v && k < 60);
        chk(r & m, v);
    endtask : poll

    task automatic count(input int n);
        t1 = 0;
        repeat (n)
        begin
            @(posedge pclk);
            t1 += brake_drive;
        end
    endtask : count

    task automatic wait_on(input bit f);
        t1 = 0;
        while ((f ? output_block : speed_loss_flag) !== 1'b1 && t1 < 900)
        begin
            @(posedge pclk);
            t1++;
        end
    endtask : wait_on

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    initial
    begin
        int k;
        logic [31:0] c;
        logic [31:0] cs [8] = '{32'h0000_0FFF, 32'h0418_0FFF, 32'h140F_0FFF,
            32'h1818_0FFF, 32'h1A30_0100, 32'h0A30_0300, 32'h0900_0300,
            32'h1630_00F0};
        void'($urandom(32'h9BAD1712));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        // Defaults, refusals and random codes
        for (k = 0; k < 36; k += 4)
            rd(k);
        apb(0, 8'h2C, 0);
        chk(e, 1);
        chk(r, 0);
        for (k = 0; k < 12; k++)
        begin
            wr(k[0] ? 8 : 4, $urandom & 32'h001F_001F);
            rd(k[0] ? 8 : 4);
            wr(k[0] ? 12 : 28, k == 3 ? 0 : $urandom & 32'h7FF);
            rd(k[0] ? 12 : 28);
        end
        wr(4, 32'h0004_0003);
        wr(12, 2);
        wr(28, 10);
        // Open phase, off then on, latched
        open_cmd <= 3'b010;
        count(20);
        poll(1, 0);
        wr(0, 32'h3);
        poll(1, 1);
        chk(output_block, 1);
        wr(36, 1);
        poll(1, 1);
        open_cmd <= 0;
        count(8);
        wr(36, 1);
        poll(1, 0);
        // N.O. and N.C. trips
        wr(0, 32'h2);
        wr(4, 32'h0004_0012);
        c4 <= 1;
        poll(2, 2);
        chk(output_block, 1);
        c4 <= 0;
        count(8);
        wr(36, 1);
        poll(2, 0);
        c5 <= 1;
        wr(4, 32'h0013_0003);
        count(20);
        poll(4, 0);
        c5 <= 0;
        poll(4, 4);
        wr(4, 32'h0004_0003);
        c5 <= 1;
        count(8);
        wr(36, 1);
        poll(4, 4);
        wr(4, 32'h0013_0003);
        wr(36, 1);
        poll(4, 0);
        // Overload: larger excess trips sooner
        wr(8, 32'h0006_000B);
        for (k = 0; k < 2; k++)
        begin
            l_cmd <= k ? 12'hA00 : 12'hFFF;
            wait_on(1);
            if (k == 0)
                t2 = t1;
            poll(8, 8);
            chk(digital_output2, 1);
            l_cmd <= 0;
            wr(36, 1);
            poll(8, 0);
        end
        chk(t2 <= 11 * T + 4 && t1 >= 30 * T, 1);
        // Loss criteria and sources, reaction 0
        foreach (cs[k])
        begin
            c = cs[k];
            wr(0, {24'h0, c[25:24], 2'h0, c[27:26], 2'h2});
            v_cmd <= c[23:12];
            i_cmd <= c[11:0];
            repeat (40) @(posedge pclk);
            poll(32, c[28] ? 32 : 0);
            chk(speed_loss_flag, c[28]);
            chk(relay_output, c[28]);
            chk(output_block, 0);
            v_cmd <= 12'hFFF;
            i_cmd <= 12'hFFF;
        end
        // Qualification time at two settings
        wr(0, 32'hA);
        for (k = 1; k < 4; k += 2)
        begin
            wr(12, k);
            v_cmd <= 0;
            wait_on(0);
            chk(t1 >= (k - 1) * T && t1 <= (k + 1) * T + 3, 1);
            v_cmd <= 12'hFFF;
        end
        // Decel and coast reactions
        wr(12, 2);
        wr(0, 32'h2A);
        v_cmd <= 0;
        poll(64, 64);
        chk({decel_stop_req, output_block}, 2);
        wr(0, 32'h1A);
        poll(16, 16);
        chk(output_block, 1);
        v_cmd <= 12'hFFF;
        wr(36, 1);
        poll(16, 0);
        // Brake: free with cap, then duty 0 and 10
        wr(0, 32'h0);
        wr(28, 0);
        brake_request <= 1;
        count(1700);
        chk(t1 >= 15 * 10 * T - 10 && t1 <= 15 * 10 * T + 12, 1);
        poll(128, 128);
        brake_request <= 0;
        wr(0, 32'h2);
        brake_request <= 1;
        count(300);
        chk(t1, 0);
        brake_request <= 0;
        wr(28, 10);
        brake_request <= 1;
        count(2000);
        chk(t1 >= 9 * T && t1 <= 33 * T + 3, 1);
        brake_request <= 0;
        stop_test();
    end
endmodule : drive_protection_supervisor_tb_top
`default_nettype wire
